/* sps_stack.sv */
`timescale 1ns/1ps
`default_nettype none

module sps_stack (
  input wire logic clk,
  input wire logic reset,
  input wire logic legacy_mode,
  input wire logic op_valid,
  input wire sps_pkg::sps_kind_type op_kind,
  input wire logic op_size32,
  input wire logic stack_32,
  input wire logic [31:0] seg_limit,
  input wire logic [15:0] op_sel,
  input wire logic [31:0] op_data,
  input wire logic [31:0] idx_disp,
  input wire logic dest_sp_base,
  input wire logic sp_load,
  input wire logic [31:0] sp_load_value,
  input wire logic branch_done,
  input wire logic branch_fault,
  input wire logic mem_ack,
  input wire logic mem_page_fault,
  input wire logic [31:0] mem_rdata,
  output logic op_ready,
  output logic op_done,
  output logic op_fault,
  output logic [31:0] stack_pointer,
  output logic [31:0] pop_data,
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  output logic fault_stack,
  output logic fault_limit,
  output logic fault_page
);
  import sps_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sps_state_type state;
    sps_kind_type kind;
    logic size32;
    logic stack_32;
    logic step;
    logic [31:0] sp;
    logic [31:0] sp_start;
    logic [31:0] sp_next;
    logic [15:0] sel;
    logic [31:0] data;
    logic [31:0] idx;
    logic dest_sp;
    logic mem_req;
    logic mem_write;
    logic [31:0] mem_addr;
    logic [3:0] mem_be;
    logic [31:0] mem_wdata;
    logic [31:0] pop_data;
    logic fault;
  } sps_regs_type;

  sps_regs_type st_r;
  sps_regs_type st_nxt;

  logic [2:0] nbytes;
  logic [2:0] delta;
  logic [3:0] be;
  logic is_pop;
  logic [31:0] new_sp;
  logic [31:0] acc_addr;
  logic [31:0] acc_wdata;
  logic [32:0] last_byte;
  logic wrapped;
  logic lim_err;
  logic ss_err;
  logic page_err;

  // ****************************************
  // Helpers
  // ****************************************
  // A 16-bit stack addresses and moves only the low half
  function automatic logic [31:0] stack_addr(input logic [31:0] sp, input logic s32);
    stack_addr = s32 ? sp : {SPS_ZERO_HALF, sp[15:0]};
  endfunction

  function automatic logic [31:0] sp_commit(input logic [31:0] old_sp, input logic [31:0] upd,
                                            input logic s32);
    sp_commit = s32 ? upd : {old_sp[31:16], upd[15:0]};
  endfunction

  sps_size u_size (
    .kind(st_r.kind),
    .step(st_r.step),
    .size32(st_r.size32),
    .legacy_mode(legacy_mode),
    .nbytes(nbytes),
    .delta(delta),
    .be(be),
    .is_pop(is_pop)
  );

  // ****************************************
  // Access formation
  // ****************************************
  always_comb begin
    new_sp = is_pop ? st_r.sp + {29'h0, delta} : st_r.sp - {29'h0, delta};
    acc_addr = is_pop ? stack_addr(st_r.sp, st_r.stack_32) : stack_addr(new_sp, st_r.stack_32);
    wrapped = !st_r.stack_32 && (st_r.sp[15:0] < st_r.sp_start[15:0]);
    ss_err = 1'b0;
    acc_wdata = st_r.pop_data;
    unique case (st_r.kind)
      SPS_PUSH_SEL: begin
        acc_wdata = {SPS_ZERO_HALF, st_r.sel};
      end
      SPS_FAR_CALL: begin
        acc_wdata = st_r.step ? st_r.data : {SPS_ZERO_HALF, st_r.sel};
      end
      SPS_PUSH_ERR, SPS_PUSH_SP16: begin
        acc_wdata = {SPS_ZERO_HALF, st_r.data[15:0]};
      end
      SPS_POP_MEM: begin
        if (st_r.step) begin
          new_sp = st_r.sp;
          if (!st_r.dest_sp) begin
            acc_addr = st_r.idx;
          end else if (legacy_mode && wrapped) begin
            // Legacy wrap: small segment faults, large one writes past 64K
            ss_err = (seg_limit <= SPS_SEG64K_LIMIT);
            acc_addr = {15'h0, SPS_WRAP_BASE} + st_r.idx;
          end else begin
            acc_addr = stack_addr(st_r.sp, st_r.stack_32) + st_r.idx;
          end
        end
      end
      default: begin
        acc_wdata = st_r.pop_data;
      end
    endcase
    last_byte = {1'b0, acc_addr} + {30'h0, nbytes} - 33'h0_0000_0001;
    // Only bytes really touched are checked, so default mode never trips on the upper pair
    lim_err = (st_r.state == SPS_PREP) && !ss_err && (last_byte > {1'b0, seg_limit});
    page_err = (st_r.state == SPS_ACC) && mem_ack && mem_page_fault;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      SPS_IDLE: begin
        st_nxt.fault = 1'b0;
        if (sp_load) begin
          st_nxt.sp = sp_load_value;
        end
        if (op_valid) begin
          st_nxt.kind = op_kind;
          st_nxt.size32 = op_size32;
          st_nxt.stack_32 = stack_32;
          st_nxt.step = 1'b0;
          st_nxt.sel = op_sel;
          st_nxt.data = op_data;
          st_nxt.idx = idx_disp;
          st_nxt.dest_sp = dest_sp_base;
          st_nxt.sp_start = sp_load ? sp_load_value : st_r.sp;
          st_nxt.state = (op_kind == SPS_FAR_CALL) ? SPS_BRCHK : SPS_PREP;
        end
      end
      SPS_BRCHK: begin
        // No push issues until the branch target has been cleared
        if (branch_done) begin
          if (branch_fault) begin
            st_nxt.fault = 1'b1;
            st_nxt.state = SPS_DONE;
          end else begin
            st_nxt.state = SPS_PREP;
          end
        end
      end
      SPS_PREP: begin
        if (lim_err || ss_err) begin
          st_nxt.sp = st_r.sp_start;
          st_nxt.fault = 1'b1;
          st_nxt.state = SPS_DONE;
        end else begin
          st_nxt.sp_next = sp_commit(st_r.sp, new_sp, st_r.stack_32);
          st_nxt.mem_req = 1'b1;
          st_nxt.mem_write = !is_pop;
          st_nxt.mem_addr = acc_addr;
          st_nxt.mem_be = be;
          st_nxt.mem_wdata = acc_wdata;
          st_nxt.state = SPS_ACC;
        end
      end
      SPS_ACC: begin
        if (mem_ack) begin
          st_nxt.mem_req = 1'b0;
          if (mem_page_fault) begin
            st_nxt.sp = st_r.sp_start;
            st_nxt.fault = 1'b1;
            st_nxt.state = SPS_DONE;
          end else begin
            st_nxt.sp = st_r.sp_next;
            if (is_pop) begin
              st_nxt.pop_data = (nbytes == SPS_BYTES_DWORD) ? mem_rdata : {SPS_ZERO_HALF, mem_rdata[15:0]};
            end
            if (st_r.kind == SPS_RET_SP16) begin
              st_nxt.sp = {SPS_ZERO_HALF, mem_rdata[15:0]};
            end
            if ((st_r.kind == SPS_FAR_CALL || st_r.kind == SPS_POP_MEM) && !st_r.step) begin
              st_nxt.step = 1'b1;
              st_nxt.state = SPS_PREP;
            end else begin
              st_nxt.state = SPS_DONE;
            end
          end
        end
      end
      SPS_DONE: begin
        st_nxt.state = SPS_IDLE;
      end
      default: begin
        st_nxt.state = SPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.state <= SPS_IDLE;
      st_r.kind <= SPS_PUSH_SEL;
      st_r.sp <= SPS_SP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign op_ready = (st_r.state == SPS_IDLE);
  assign op_done = (st_r.state == SPS_DONE);
  assign op_fault = st_r.fault;
  assign stack_pointer = st_r.sp;
  assign pop_data = st_r.pop_data;
  assign mem_req = st_r.mem_req;
  assign mem_write = st_r.mem_write;
  assign mem_addr = st_r.mem_addr;
  assign mem_be = st_r.mem_be;
  assign mem_wdata = st_r.mem_wdata;
  // Combinational so the report lands in the cycle the access is withheld
  assign fault_stack = (st_r.state == SPS_PREP) && ss_err;
  assign fault_limit = lim_err;
  assign fault_page = page_err;

endmodule

`default_nettype wire

/* sps_size.sv */
// ****************************************
// Shared constants and types
// ****************************************
package sps_pkg;

  localparam logic [31:0] SPS_SP_RESET = 32'h0000_0000;
  localparam logic [31:0] SPS_SEG64K_LIMIT = 32'h0000_FFFF;
  localparam logic [16:0] SPS_WRAP_BASE = 17'h1_0000;
  localparam logic [2:0] SPS_BYTES_WORD = 3'h2;
  localparam logic [2:0] SPS_BYTES_DWORD = 3'h4;
  localparam logic [3:0] SPS_BE_WORD = 4'h3;
  localparam logic [3:0] SPS_BE_DWORD = 4'hF;
  localparam logic [15:0] SPS_ZERO_HALF = 16'h0000;

  typedef enum logic [2:0] {
    SPS_PUSH_SEL = 3'h0,
    SPS_POP_SEL = 3'h1,
    SPS_PUSH_ERR = 3'h2,
    SPS_FAR_CALL = 3'h3,
    SPS_POP_MEM = 3'h4,
    SPS_PUSH_SP16 = 3'h5,
    SPS_RET_SP16 = 3'h6
  } sps_kind_type;

  typedef enum logic [2:0] {
    SPS_IDLE = 3'h0,
    SPS_BRCHK = 3'h1,
    SPS_PREP = 3'h2,
    SPS_ACC = 3'h3,
    SPS_DONE = 3'h4
  } sps_state_type;

endpackage

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Access sizing decode
// ****************************************
module sps_size (
  input wire sps_pkg::sps_kind_type kind,
  input wire logic step,
  input wire logic size32,
  input wire logic legacy_mode,
  output logic [2:0] nbytes,
  output logic [2:0] delta,
  output logic [3:0] be,
  output logic is_pop
);
  import sps_pkg::*;

  logic [2:0] opsz;

  always_comb begin
    opsz = size32 ? SPS_BYTES_DWORD : SPS_BYTES_WORD;
    delta = opsz;
    nbytes = opsz;
    is_pop = 1'b0;
    unique case (kind)
      SPS_PUSH_SEL: begin
        nbytes = legacy_mode ? opsz : SPS_BYTES_WORD;
      end
      SPS_POP_SEL: begin
        is_pop = 1'b1;
        nbytes = legacy_mode ? opsz : SPS_BYTES_WORD;
      end
      SPS_PUSH_ERR: begin
        delta = SPS_BYTES_DWORD;
        nbytes = SPS_BYTES_DWORD;
      end
      SPS_FAR_CALL: begin
        is_pop = 1'b0;
      end
      SPS_POP_MEM: begin
        is_pop = !step;
      end
      SPS_PUSH_SP16: begin
        delta = SPS_BYTES_WORD;
        nbytes = SPS_BYTES_WORD;
      end
      SPS_RET_SP16: begin
        is_pop = 1'b1;
        delta = SPS_BYTES_WORD;
        nbytes = SPS_BYTES_WORD;
      end
      default: begin
        is_pop = 1'b0;
      end
    endcase
    be = (nbytes == SPS_BYTES_DWORD) ? SPS_BE_DWORD : SPS_BE_WORD;
  end

endmodule

`default_nettype wire

/* sps_stack_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Stack access checks
// ****
module sps_stack_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic op_fault,
  input wire logic [31:0] stack_pointer,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_page_fault,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic fault_stack,
  input wire logic fault_limit,
  input wire logic fault_page
);
  logic [31:0] sp_take_r;
  // Pointer at take, the value a fault must bring back
  always_ff @(posedge clk) begin
    if (reset) begin
      sp_take_r <= 32'h0000_0000;
    end else if (op_ready && op_valid) begin
      sp_take_r <= stack_pointer;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_be); endproperty
  a_hold: assert property (p_hold) else $error("request moved before ack");
  property p_be; mem_req |-> mem_be == 4'h3 || mem_be == 4'hF; endproperty
  a_be: assert property (p_be) else $error("bad byte enables");
  property p_drop; mem_req && mem_ack |=> !mem_req; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_idle; op_ready |-> !mem_req; endproperty
  a_idle: assert property (p_idle) else $error("access while idle");
  property p_page; mem_req && mem_ack && mem_page_fault |-> fault_page; endproperty
  a_page: assert property (p_page) else $error("page fault not reported");
  property p_lim; fault_limit || fault_stack |=> !mem_req ##[0:2] (op_done && op_fault); endproperty
  a_lim: assert property (p_lim) else $error("limit fault mishandled");
  property p_pgdone; fault_page |=> ##[0:2] (op_done && op_fault); endproperty
  a_pgdone: assert property (p_pgdone) else $error("page fault not ended");
  property p_restore; op_done && op_fault |=> stack_pointer == sp_take_r; endproperty
  a_restore: assert property (p_restore) else $error("pointer not restored");
  property p_done; op_done |=> !op_done && op_ready; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
endmodule
bind sps_stack sps_stack_asserts u_sps_stack_asserts (.clk, .reset, .op_valid, .op_ready, .op_done, .op_fault,
  .stack_pointer, .mem_req, .mem_ack, .mem_page_fault, .mem_addr, .mem_be, .fault_stack, .fault_limit, .fault_page);
`default_nettype wire

/* sps_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Stack memory model
// ****
module sps_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] lat,
  input wire logic pf,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic mem_page_fault,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt_r;
  logic [31:0] rd;
  logic [31:0] last_waddr;
  int wr_count;
  assign mem_ack = mem_req && cnt_r == lat;
  assign mem_page_fault = mem_ack && pf;
  always_comb begin
    for (int i = 0; i < 4; i++) rd[8*i +: 8] = mem[8'(mem_addr + i)];
  end
  // Inverse outside ack so stale data never looks valid
  assign mem_rdata = mem_ack ? rd : ~rd;
  // Fill on reset so only one process ever writes the array
  always @(posedge clk) begin
    cnt_r <= (reset || !mem_req || mem_ack) ? 2'h0 : cnt_r + 2'h1;
    if (reset) begin
      wr_count <= 0;
      for (int i = 0; i < 256; i++) mem[i] <= 8'hA5;
    end else if (mem_ack && mem_write && !pf) begin
      wr_count <= wr_count + 1;
      last_waddr <= mem_addr;
      for (int i = 0; i < 4; i++) if (mem_be[i]) mem[8'(mem_addr + i)] <= mem_wdata[8*i +: 8];
    end
  end
endmodule
`default_nettype wire

/* sps_stack_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sps_stack_tb;
  import sps_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic legacy_mode, op_valid, op_size32, stack_32, dest_sp_base, sp_load, branch_done, branch_fault, pf, flt;
  logic [1:0] lat;
  logic [2:0] fl;
  logic [15:0] op_sel;
  logic [31:0] seg_limit, op_data, idx_disp, sp_load_value, b, w;
  sps_kind_type op_kind;
  logic op_ready, op_done, op_fault, mem_req, mem_write, mem_ack, mem_page_fault, fault_stack, fault_limit, fault_page;
  logic [31:0] stack_pointer, pop_data, mem_addr, mem_wdata, mem_rdata;
  logic [3:0] mem_be;
  int fails = 0;
  int compares = 0;
  int seed = 32'h96705FD6;
  always #5 clk = ~clk;
  sps_stack u_sps_stack (.clk, .reset, .legacy_mode, .op_valid, .op_kind, .op_size32, .stack_32, .seg_limit, .op_sel,
    .op_data, .idx_disp, .dest_sp_base, .sp_load, .sp_load_value, .branch_done, .branch_fault, .mem_ack,
    .mem_page_fault, .mem_rdata, .op_ready, .op_done, .op_fault, .stack_pointer, .pop_data, .mem_req, .mem_write,
    .mem_addr, .mem_be, .mem_wdata, .fault_stack, .fault_limit, .fault_page);
  sps_mem_model u_sps_mem_model (.clk, .reset, .lat, .pf, .mem_req, .mem_write, .mem_addr, .mem_be, .mem_wdata,
    .mem_ack, .mem_page_fault, .mem_rdata);
  function automatic logic [31:0] rdw(input logic [31:0] a);
    for (int i = 0; i < 4; i++) rdw[8*i +: 8] = u_sps_mem_model.mem[8'(a + i)];
  endfunction
  // Untouched bytes keep the A5 fill
  function automatic logic [31:0] sel_word(input logic lg, input logic s32, input logic [15:0] s);
    sel_word = !s32 ? {s, 16'hA5A5} : {(lg ? 16'h0000 : 16'hA5A5), s};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic setsp(input logic [31:0] v);
    @(negedge clk);
    sp_load = 1'b1;
    sp_load_value = v;
    @(negedge clk);
    sp_load = 1'b0;
  endtask
  task automatic op(input sps_kind_type k, input logic s32);
    int n;
    n = 0;
    @(negedge clk);
    op_kind = k;
    op_size32 = s32;
    lat = 2'($random(seed));
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    fl = {fault_stack, fault_limit, fault_page};
    while (op_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      fl = fl | {fault_stack, fault_limit, fault_page};
      n++;
    end
    flt = op_fault;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
    @(negedge clk);
  endtask
  initial begin
    {legacy_mode, op_valid, op_size32, dest_sp_base, sp_load, branch_done, branch_fault, pf} = '0;
    stack_32 = 1'b1;
    lat = 2'h0;
    op_sel = 16'h0000;
    {op_data, idx_disp, sp_load_value} = '0;
    seg_limit = 32'hFFFF_FFFF;
    op_kind = SPS_PUSH_SEL;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int m = 0; m < 4; m++) begin
      legacy_mode = m[1];
      b = 32'h40 * m + 32'h20;
      op_sel = 16'($random(seed));
      setsp(b);
      op(SPS_PUSH_SEL, m[0]);
      chk("push sp", b - (m[0] ? 32'h4 : 32'h2), stack_pointer);
      chk("push data", sel_word(m[1], m[0], op_sel), rdw(b - 32'h4));
      chk("push flags", 32'h0, {29'h0, fl});
      setsp(b + 32'h10);
      op(SPS_POP_SEL, m[0]);
      chk("pop data", (m == 3) ? 32'hA5A5A5A5 : 32'h0000A5A5, pop_data);
      chk("pop sp", b + 32'h10 + (m[0] ? 32'h4 : 32'h2), stack_pointer);
      if (m[0]) begin
        seg_limit = b - 32'h3;
        setsp(b);
        op(SPS_PUSH_SEL, 1'b1);
        chk("limit fault", {31'h0, m[1]}, {31'h0, flt});
        chk("limit sp", m[1] ? b : b - 32'h4, stack_pointer);
        chk("limit flag", {31'h0, m[1]}, {31'h0, fl[1]});
        seg_limit = 32'hFFFF_FFFF;
      end
    end
    legacy_mode = 1'b0;
    op_data = $random(seed);
    setsp(32'hC0);
    op(SPS_PUSH_ERR, 1'b0);
    chk("err sp", 32'hBC, stack_pointer);
    chk("err data", {16'h0000, op_data[15:0]}, rdw(32'hBC));
    branch_done = 1'b1;
    branch_fault = 1'b1;
    w = u_sps_mem_model.wr_count;
    setsp(32'h90);
    op(SPS_FAR_CALL, 1'b1);
    chk("branch fault", 32'h1, {31'h0, flt});
    chk("branch writes", w, u_sps_mem_model.wr_count);
    chk("branch sp", 32'h90, stack_pointer);
    branch_fault = 1'b0;
    op(SPS_FAR_CALL, 1'b1);
    chk("call sp", 32'h88, stack_pointer);
    chk("call ptr", op_data, rdw(32'h88));
    chk("call sel", {16'h0000, op_sel}, rdw(32'h8C));
    pf = 1'b1;
    op(SPS_PUSH_SEL, 1'b1);
    chk("page fault", 32'h1, {31'h0, flt});
    chk("page sp", 32'h88, stack_pointer);
    chk("page flag", 32'h1, {31'h0, fl[0]});
    pf = 1'b0;
    setsp(32'hFFFF_0040);
    op(SPS_PUSH_SP16, 1'b0);
    chk("gate sp", 32'hFFFF_003E, stack_pointer);
    chk("gate data", {op_data[15:0], 16'hA5A5}, rdw(32'h3C));
    op(SPS_RET_SP16, 1'b0);
    chk("return sp", {16'h0000, op_data[15:0]}, stack_pointer);
    stack_32 = 1'b0;
    dest_sp_base = 1'b1;
    for (int c = 0; c < 6; c++) begin
      legacy_mode = (c > 1);
      seg_limit = (c > 3) ? 32'hFFFF : 32'h1_FFFF;
      idx_disp = 32'h8 + 32'h4 * c;
      setsp(c[0] ? 32'hFFFC : 32'hFFFE);
      op(SPS_POP_MEM, c[0]);
      chk("wrap fault", {31'h0, c > 3}, {31'h0, flt});
      chk("wrap flag", {31'h0, c > 3}, {31'h0, fl[2]});
      if (c < 4) begin
        chk("wrap addr", idx_disp + ((c > 1) ? 32'h1_0000 : 32'h0), u_sps_mem_model.last_waddr);
        chk("wrap sp", 32'h0, stack_pointer);
      end else begin
        chk("wrap sp", c[0] ? 32'hFFFC : 32'hFFFE, stack_pointer);
      end
    end
    dest_sp_base = 1'b0;
    idx_disp = 32'h50;
    setsp(32'h20);
    op(SPS_POP_MEM, 1'b0);
    chk("pop mem addr", 32'h50, u_sps_mem_model.last_waddr);
    chk("pop mem sp", 32'h22, stack_pointer);
    chk("pop mem flags", 32'h0, {29'h0, fl});
    give_verdict();
  end
endmodule
`default_nettype wire
